// ### mcp_exception_unit.sv
`include "mcp_regs.svh"
// Contract
// - masked i/o machine checks stay pending
// - i/o check waits completion, length zero
// - channel write faults coded 0CCC 5/8/9
// - channel stall after reset gives 0CCC0110
// - status table 0C, timer word 0D
// - three-bit field carries channel number
// - processor check aborts; masked means halt
// - processor storage faults coded 111T 5/7-A
// - control storage write error 111T0110
// - unmasked-off program exception gives 111T1100
// - processor stall timer gives 111T1111
// - processor T: suppressed 0, terminated 1
// - equipment fault 111T0000, held while masked
// - equipment waits completion unless terminable
// - program exception aborts; entry needs mask
// - program mask zero ignores maskable exceptions
// - program exception mask off: machine check or halt
// - program exception codes 000T 1 to 7
// - overflow codes 8 and A, bits B D
// - float exponent and significance codes
// - divide fault codes 9, B, F
// - indirect word A flag, chain over 8
// - program T: suppressed 0, terminated 1
// - fatal error: cycle, reset, lamp, stop
module mcp_exception_unit
   import mcp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic instrDone,
   input wire logic entryDone,
   input wire logic ioFault,
   input wire mcp_io_kind_t ioKind,
   input wire logic [2:0] ioChan,
   input wire logic procFault,
   input wire mcp_proc_kind_t procKind,
   input wire logic procTerm,
   input wire logic equipFault,
   input wire logic equipMayTerm,
   input wire logic progExc,
   input wire mcp_prog_cause_t progCause,
   input wire logic progTerm,
   input wire logic fpCheck,
   input wire logic signed [9:0] fpExp,
   input wire logic fpAddSub,
   input wire logic fpZeroFrac,
   input wire logic iacwCheck,
   input wire logic iacwAFlag,
   input wire logic [3:0] iacwCount,
   output logic entrySeqReq,
   output logic [7:0] intCode,
   output logic lengthCodeZero,
   output logic abortInstr,
   output logic nonrecov,
   output logic cycleMode,
   output logic chanSysReset,
   output logic checkOut,
   output logic checkLamp,
   output logic procStop
);
   // ==========================================================
   // state
   // ==========================================================
   mcp_state_t state_r, state_nxt; // engine state
   logic [5:0] mask_r; // mask bits of the current status word
   logic [7:0] code_r, code_nxt; // code for the old status word
   logic req_r, req_nxt; // entry sequence request
   logic lenZero_r, lenZero_nxt; // length code forced to zero
   logic abort_r, abort_nxt; // suppress or terminate now
   logic fatal_r; // nonrecoverable error latched
   logic ioPend_r; // i/o machine check pending
   logic [7:0] ioCode_r; // code of the pending i/o check
   logic equipPend_r; // equipment check pending
   logic equipDly_r; // equipment line, last cycle
   logic [7:0] rd_r; // read data register

   // ==========================================================
   // decode of masks and register port
   // ==========================================================
   wire mcMask = mask_r[`MCP_BIT_MC];
   wire pxMask = mask_r[`MCP_BIT_PX];
   wire wrMask = regWr && (regAddr == `MCP_ADDR_MASK);
   wire idle = (state_r == MCP_IDLE);

   // ==========================================================
   // i/o machine check code
   // ==========================================================
   logic [7:0] ioCodeNow; // code of the fault seen this cycle
   always_comb begin
      case (ioKind)
         MCP_IOK_ADDRPROT: ioCodeNow = {1'b0, ioChan, `MCP_IO_ADDRPROT};
         MCP_IOK_ADDRCHK: ioCodeNow = {1'b0, ioChan, `MCP_IO_ADDRCHK};
         MCP_IOK_PARITY: ioCodeNow = {1'b0, ioChan, `MCP_IO_PARITY};
         MCP_IOK_STALL: ioCodeNow = {1'b0, ioChan, `MCP_IO_STALL};
         MCP_IOK_TABLE: ioCodeNow = `MCP_IO_TABLE;
         MCP_IOK_TIMER: ioCodeNow = `MCP_IO_TIMER;
         default: ioCodeNow = {1'b0, ioChan, `MCP_IO_ADDRPROT};
      endcase
   end

   // ==========================================================
   // program exception classification
   // ==========================================================
   wire fpOvf = fpCheck && (fpExp > `MCP_EXP_MAX);
   wire fpUnf = fpCheck && (fpExp < 10'sd0);
   wire fpSig = fpCheck && fpAddSub && fpZeroFrac;
   wire iacwA = iacwCheck && iacwAFlag;
   wire iacwLong = iacwCheck && (iacwCount > `MCP_INDIRECT_ADDRESS_CONTROL_WORD_MAX);
   logic [7:0] progCode; // chosen program code with T
   logic progHit; // some program exception this cycle
   logic pmBit; // program mask bit that applies, 1 if none
   // a decoded cause outranks the float and indirect checks
   always_comb begin
      progHit = 1'b1;
      pmBit = 1'b1;
      progCode = {`MCP_PFX_PROG, progTerm, progCause};
      if (progExc) begin
         if (progCause == MCP_PX_FXOVF) begin
            pmBit = mask_r[`MCP_BIT_PM_B];
         end else if (progCause == MCP_PX_DECOVF) begin
            pmBit = mask_r[`MCP_BIT_PM_D];
         end
      end else if (fpOvf) begin
         progCode = {`MCP_PFX_PROG, progTerm, `MCP_PG_EXPOVF};
      end else if (fpUnf) begin
         progCode = {`MCP_PFX_PROG, progTerm, `MCP_PG_EXPUNF};
         pmBit = mask_r[`MCP_BIT_PM_E];
      end else if (fpSig) begin
         progCode = {`MCP_PFX_PROG, progTerm, `MCP_PG_SIGNIF};
         pmBit = mask_r[`MCP_BIT_PM_S];
      end else if (iacwA) begin
         progCode = {`MCP_PFX_IND, progTerm, `MCP_IN_AFLAG};
      end else if (iacwLong) begin
         progCode = {`MCP_PFX_IND, progTerm, `MCP_IN_CHAIN};
      end else begin
         progHit = 1'b0;
      end
   end
   // a zero program mask bit lets the instruction run on
   wire progLive = progHit && pmBit;

   // ==========================================================
   // processor machine check code
   // ==========================================================
   wire procLive = procFault || (progLive && !pxMask);
   logic [3:0] procNib; // low nibble of the processor code
   always_comb begin
      case (procKind)
         MCP_PRK_ADDRPROT: procNib = `MCP_PR_ADDRPROT;
         MCP_PRK_CSWRITE: procNib = `MCP_PR_CSWRITE;
         MCP_PRK_RDBUS: procNib = `MCP_PR_RDBUS;
         MCP_PRK_ADDRCHK: procNib = `MCP_PR_ADDRCHK;
         MCP_PRK_WRBUS: procNib = `MCP_PR_WRBUS;
         MCP_PRK_RDCHK: procNib = `MCP_PR_RDCHK;
         MCP_PRK_STALL: procNib = `MCP_PR_STALL;
         default: procNib = `MCP_PR_STALL;
      endcase
   end
   // the converted program exception loses its own cause
   wire [7:0] procCode = procFault ?
      {`MCP_PFX_PROC, procTerm, procNib} :
      {`MCP_PFX_PROC, progTerm, `MCP_PR_PROGMASK};

   // equipment: terminate only where the instruction allows
   wire equipTerm = equipMayTerm && !instrDone;
   wire equipGo = equipPend_r && mcMask && (instrDone || equipMayTerm);
   wire ioGo = ioPend_r && mcMask && instrDone;
   wire equipRise = equipFault && !equipDly_r;

   // ==========================================================
   // next-state logic, fixed priority among classes
   // ==========================================================
   // processor > program > equipment > i/o
   always_comb begin
      state_nxt = state_r;
      code_nxt = code_r;
      req_nxt = req_r;
      lenZero_nxt = lenZero_r;
      abort_nxt = abort_r;
      case (state_r)
         MCP_IDLE: begin
            if (procLive) begin
               if (mcMask) begin
                  state_nxt = MCP_ENTRY;
                  code_nxt = procCode;
                  req_nxt = 1'b1;
                  abort_nxt = 1'b1;
                  lenZero_nxt = 1'b0;
               end else begin
                  state_nxt = MCP_HALT;
               end
            end else if (progLive) begin
               state_nxt = MCP_ENTRY;
               code_nxt = progCode;
               req_nxt = 1'b1;
               abort_nxt = 1'b1;
               lenZero_nxt = 1'b0;
            end else if (equipGo) begin
               state_nxt = MCP_ENTRY;
               code_nxt = {`MCP_PFX_PROC, equipTerm, `MCP_EQ_NIB};
               req_nxt = 1'b1;
               abort_nxt = equipTerm;
               lenZero_nxt = !equipTerm;
            end else if (ioGo) begin
               state_nxt = MCP_ENTRY;
               code_nxt = ioCode_r;
               req_nxt = 1'b1;
               abort_nxt = 1'b0;
               lenZero_nxt = 1'b1;
            end
         end
         MCP_ENTRY: begin
            // a hardware fault inside the entry sequence is fatal
            if (procFault) begin
               state_nxt = MCP_HALT;
               req_nxt = 1'b0;
            end else if (entryDone) begin
               state_nxt = MCP_IDLE;
               req_nxt = 1'b0;
               abort_nxt = 1'b0;
            end
         end
         MCP_HALT: begin
            req_nxt = 1'b0; // stays until reset
         end
         default: begin
            state_nxt = MCP_IDLE;
            req_nxt = 1'b0;
         end
      endcase
   end
   wire ioTaken = idle && !procLive && !progLive && !equipGo && ioGo;
   wire equipTaken = idle && !procLive && !progLive && equipGo;

   // ==========================================================
   // registers
   // ==========================================================
   // engine and code registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= MCP_IDLE;
         code_r <= 8'h00;
         req_r <= 1'b0;
         lenZero_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         code_r <= code_nxt;
         req_r <= req_nxt;
         lenZero_r <= lenZero_nxt;
         abort_r <= abort_nxt;
      end
   end

   // fatal latch drives all the halt outputs together
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fatal_r <= 1'b0;
      end else if (state_nxt == MCP_HALT) begin
         fatal_r <= 1'b1;
      end
   end

   // i/o pending; a new fault in the take cycle is kept (set wins)
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ioPend_r <= 1'b0;
         ioCode_r <= 8'h00;
      end else if (ioFault && (!ioPend_r || ioTaken)) begin
         ioPend_r <= 1'b1;
         ioCode_r <= ioCodeNow;
      end else if (ioTaken) begin
         ioPend_r <= 1'b0;
      end
   end

   // equipment pending on the line's rising edge, set wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         equipPend_r <= 1'b0;
         equipDly_r <= 1'b0;
      end else begin
         equipDly_r <= equipFault;
         equipPend_r <= equipRise || (equipPend_r && !equipTaken);
      end
   end

   // masks written by software; all closed after reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mask_r <= `MCP_MASK_RST;
      end else if (wrMask) begin
         mask_r <= regWrData[5:0];
      end
   end

   // read data valid the cycle after the strobe only
   wire [7:0] statWord = {2'b00, fatal_r, state_r, equipPend_r,
                          ioPend_r, req_r};
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_r <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `MCP_ADDR_MASK: rd_r <= {2'b00, mask_r};
            `MCP_ADDR_CODE: rd_r <= code_r;
            `MCP_ADDR_STAT: rd_r <= statWord;
            default: rd_r <= 8'h00;
         endcase
      end else begin
         rd_r <= 8'h00;
      end
   end

   // ==========================================================
   // outputs, all from flip-flops
   // ==========================================================
   assign regRdData = rd_r;
   assign entrySeqReq = req_r;
   assign intCode = code_r;
   assign lengthCodeZero = lenZero_r;
   assign abortInstr = abort_r;
   assign nonrecov = fatal_r;
   assign cycleMode = fatal_r;
   assign chanSysReset = fatal_r;
   assign checkOut = fatal_r;
   assign checkLamp = fatal_r;
   assign procStop = fatal_r;

   // ==========================================================
   // checks
   // ==========================================================
   chk_io_held_masked: assert property (@(posedge clk) disable iff (sys_rst)
      ioPend_r && !mcMask && idle && !progLive |=> ioPend_r && !req_r)
      else $error("i/o check lost or taken while masked");
   chk_io_len_zero: assert property (@(posedge clk) disable iff (sys_rst)
      ioTaken |=> req_r && lenZero_r && !abort_r && code_r[7] == 1'b0)
      else $error("i/o check entry not clean");
   chk_proc_abort: assert property (@(posedge clk) disable iff (sys_rst)
      idle && procFault && mcMask |=> req_r && abort_r && code_r[7:5] == 3'h7)
      else $error("processor check did not enter");
   chk_proc_fatal: assert property (@(posedge clk) disable iff (sys_rst)
      idle && procFault && !mcMask |=> ##1 procStop && checkLamp)
      else $error("masked processor check not fatal");
   chk_stall_code: assert property (@(posedge clk) disable iff (sys_rst)
      idle && procFault && mcMask && procKind == MCP_PRK_STALL
      |=> code_r == {3'h7, $past(procTerm), 4'hF})
      else $error("stall code wrong");
   chk_prog_convert: assert property (@(posedge clk) disable iff (sys_rst)
      idle && !procFault && progLive && !pxMask && mcMask
      |=> code_r[7:5] == 3'h7 && code_r[3:0] == 4'hC)
      else $error("program exception not converted");
   chk_pmask_ignore: assert property (@(posedge clk) disable iff (sys_rst)
      idle && progExc && progCause == MCP_PX_FXOVF && !mask_r[2]
      && !procFault && !equipGo && !ioGo |=> !req_r && !nonrecov)
      else $error("masked overflow not ignored");
   chk_fp_ovf: assert property (@(posedge clk) disable iff (sys_rst)
      idle && !procFault && !progExc && fpCheck && fpExp > 10'sd127
      && pxMask |=> code_r == {3'h0, $past(progTerm), 4'hC})
      else $error("exponent overflow code wrong");
   chk_indirect_address_control_word_chain: assert property (@(posedge clk) disable iff (sys_rst)
      idle && !procFault && !progExc && !fpCheck && iacwCheck && !iacwAFlag
      && iacwCount == 4'd9 && pxMask |=> code_r[3:0] == 4'h6)
      else $error("chain limit code wrong");
   chk_fatal_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      nonrecov |=> (nonrecov && cycleMode && chanSysReset && checkOut) [*2])
      else $error("fatal outputs dropped");
   cov_io_entry: cover property (@(posedge clk) disable iff (sys_rst)
      ioTaken ##1 req_r ##[1:20] entryDone);
   cov_equip_term: cover property (@(posedge clk) disable iff (sys_rst)
      equipTaken && equipTerm);
   cov_prog_entry: cover property (@(posedge clk) disable iff (sys_rst)
      idle && progLive && pxMask && !procFault);
   cov_fatal: cover property (@(posedge clk) disable iff (sys_rst)
      $rose(nonrecov));
endmodule // mcp_exception_unit

// ### mcp_far_model.sv
// ==========================================
// far side: supervisor running the entry sequence
module mcp_far_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic entrySeqReq,
   input wire logic [2:0] slowness,
   output logic entryDone
);
   timeunit 1ns;
   timeprecision 1ns;
   // cycles spent inside the current entry sequence
   logic [2:0] waitCnt_r;
   // ==========================================
   // entry sequence stores the old word, then reports done
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         waitCnt_r <= 3'h0;
         entryDone <= 1'b0;
      end else if (entrySeqReq && !entryDone) begin
         // slowness 0 answers at once, 7 stalls the longest
         entryDone <= (waitCnt_r >= slowness);
         waitCnt_r <= waitCnt_r + 3'h1;
      end else begin
         // done is a single pulse, never held
         entryDone <= 1'b0;
         waitCnt_r <= 3'h0;
      end
   end
endmodule // mcp_far_model

// ### mcp_pkg.sv
package mcp_pkg;
   // engine states, gray along idle -> entry -> halt
   typedef enum logic [1:0] {
      MCP_IDLE = 2'b00,
      MCP_ENTRY = 2'b01,
      MCP_HALT = 2'b11
   } mcp_state_t;
   // channel-side write fault kinds
   typedef enum logic [2:0] {
      MCP_IOK_ADDRPROT = 3'h0,
      MCP_IOK_ADDRCHK = 3'h1,
      MCP_IOK_PARITY = 3'h2,
      MCP_IOK_STALL = 3'h3,
      MCP_IOK_TABLE = 3'h4,
      MCP_IOK_TIMER = 3'h5
   } mcp_io_kind_t;
   // processor-side hardware fault kinds
   typedef enum logic [2:0] {
      MCP_PRK_ADDRPROT = 3'h0,
      MCP_PRK_CSWRITE = 3'h1,
      MCP_PRK_RDBUS = 3'h2,
      MCP_PRK_ADDRCHK = 3'h3,
      MCP_PRK_WRBUS = 3'h4,
      MCP_PRK_RDCHK = 3'h5,
      MCP_PRK_STALL = 3'h6
   } mcp_proc_kind_t;
   // program exception causes; value is the code's low nibble
   typedef enum logic [3:0] {
      MCP_PX_OPER = 4'h1,
      MCP_PX_PRIV = 4'h2,
      MCP_PX_EXEC = 4'h3,
      MCP_PX_PROT = 4'h4,
      MCP_PX_ADDR = 4'h5,
      MCP_PX_SPEC = 4'h6,
      MCP_PX_DATA = 4'h7,
      MCP_PX_FXOVF = 4'h8,
      MCP_PX_FXDIV = 4'h9,
      MCP_PX_DECOVF = 4'hA,
      MCP_PX_DECDIV = 4'hB,
      MCP_PX_FPDIV = 4'hF
   } mcp_prog_cause_t;
endpackage

// ### mcp_regs.svh
`ifndef MCP_REGS_SVH
`define MCP_REGS_SVH
// register port addresses
`define MCP_ADDR_MASK 2'h0
`define MCP_ADDR_CODE 2'h1
`define MCP_ADDR_STAT 2'h2
// mask register fields
`define MCP_BIT_PX 0
`define MCP_BIT_MC 1
`define MCP_BIT_PM_B 2
`define MCP_BIT_PM_D 3
`define MCP_BIT_PM_E 4
`define MCP_BIT_PM_S 5
`define MCP_MASK_RST 6'h00
// code prefixes (top three bits)
`define MCP_PFX_PROG 3'h0
`define MCP_PFX_IND 3'h1
`define MCP_PFX_PROC 3'h7
// i/o class low nibbles and whole codes
`define MCP_IO_ADDRPROT 4'h5
`define MCP_IO_STALL 4'h6
`define MCP_IO_ADDRCHK 4'h8
`define MCP_IO_PARITY 4'h9
`define MCP_IO_TABLE 8'h0C
`define MCP_IO_TIMER 8'h0D
// processor class low nibbles
`define MCP_PR_ADDRPROT 4'h5
`define MCP_PR_CSWRITE 4'h6
`define MCP_PR_RDBUS 4'h7
`define MCP_PR_ADDRCHK 4'h8
`define MCP_PR_WRBUS 4'h9
`define MCP_PR_RDCHK 4'hA
`define MCP_PR_PROGMASK 4'hC
`define MCP_PR_STALL 4'hF
`define MCP_EQ_NIB 4'h0
// program and indirect class low nibbles
`define MCP_PG_FXOVF 4'h8
`define MCP_PG_DECOVF 4'hA
`define MCP_PG_EXPOVF 4'hC
`define MCP_PG_EXPUNF 4'hD
`define MCP_PG_SIGNIF 4'hE
`define MCP_IN_AFLAG 4'h5
`define MCP_IN_CHAIN 4'h6
// result limits
`define MCP_EXP_MAX 10'sd127
`define MCP_INDIRECT_ADDRESS_CONTROL_WORD_MAX 4'd8
`endif

// ### tb_top.sv
// ==========================================
// bench for the exception unit
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import mcp_pkg::*;
   logic clk, sys_rst, regWr, regRd, instrDone, entryDone, ioFault;
   logic procFault, procTerm, equipFault, equipMayTerm, progExc;
   logic progTerm, fpCheck, fpAddSub, fpZeroFrac, iacwCheck, iacwAFlag;
   logic [1:0] regAddr;
   logic [7:0] regWrData, regRdData, intCode;
   mcp_io_kind_t ioKind;
   mcp_proc_kind_t procKind;
   mcp_prog_cause_t progCause;
   logic [2:0] ioChan, slowness, c;
   logic signed [9:0] fpExp;
   logic [3:0] iacwCount;
   logic entrySeqReq, lengthCodeZero, abortInstr, nonrecov, cycleMode;
   logic chanSysReset, checkOut, checkLamp, procStop, t;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   // expected {abort, length zero, code} per request, and read data
   logic [9:0] evQ[$];
   logic [7:0] rdQ[$];
   logic reqSeen = 1'b0;
   logic rdPend = 1'b0;
   // code low nibbles by fault kind
   logic [3:0] ioNib[6] = '{4'h5, 4'h8, 4'h9, 4'h6, 4'hC, 4'hD};
   logic [3:0] prNib[7] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hF};
   logic [3:0] pgc[12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                           4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
   mcp_exception_unit i_dut (.clk(clk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .instrDone(instrDone),
      .entryDone(entryDone), .ioFault(ioFault), .ioKind(ioKind),
      .ioChan(ioChan), .procFault(procFault), .procKind(procKind),
      .procTerm(procTerm), .equipFault(equipFault),
      .equipMayTerm(equipMayTerm), .progExc(progExc),
      .progCause(progCause), .progTerm(progTerm), .fpCheck(fpCheck),
      .fpExp(fpExp), .fpAddSub(fpAddSub), .fpZeroFrac(fpZeroFrac),
      .iacwCheck(iacwCheck), .iacwAFlag(iacwAFlag),
      .iacwCount(iacwCount), .entrySeqReq(entrySeqReq),
      .intCode(intCode), .lengthCodeZero(lengthCodeZero),
      .abortInstr(abortInstr), .nonrecov(nonrecov),
      .cycleMode(cycleMode), .chanSysReset(chanSysReset),
      .checkOut(checkOut), .checkLamp(checkLamp), .procStop(procStop));
   mcp_far_model i_far (.clk(clk), .sys_rst(sys_rst),
      .entrySeqReq(entrySeqReq), .slowness(slowness),
      .entryDone(entryDone));
   // ==========================================
   // checking and closing
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================
   // clock, 40 ns period, and hang guard
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop;
      end
   end
   // ==========================================
   // monitor: negedge, so strobes and outputs are settled
   always @(negedge clk) begin
      if (entrySeqReq === 1'b1 && !reqSeen) begin
         // a request with no note queued is itself a mismatch
         if (evQ.size() == 0) begin
            check(10'h3FF, 10'h000);
         end else begin
            check({abortInstr, lengthCodeZero, intCode}, evQ.pop_front());
         end
      end
      reqSeen = (entrySeqReq === 1'b1);
      if (rdPend) begin
         check({2'h0, regRdData}, {2'h0, rdQ.pop_front()});
      end
      rdPend = (regRd === 1'b1);
   end
   // ==========================================
   // register port master
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] d);
      rdQ.push_back(d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
   endtask
   // drop event pulses, end the instruction, wait out the entry
   task automatic finish_ev(input logic [9:0] exp, input logic want);
      if (want) begin
         evQ.push_back(exp);
      end
      @(posedge clk);
      {ioFault, procFault, progExc, fpCheck, iacwCheck} <= 5'h00;
      instrDone <= 1'b1;
      @(posedge clk);
      instrDone <= 1'b0;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 40 && entrySeqReq === 1'b1; i++) @(posedge clk);
      @(posedge clk);
   endtask
   // new random disposition and partner speed for the next event
   task automatic arm;
      @(posedge clk);
      t = 1'($urandom);
      procTerm <= t;
      progTerm <= t;
      slowness <= 3'($urandom);
   endtask
   // ==========================================
   // main sequence
   initial begin
      {sys_rst, regWr, regRd, instrDone, ioFault, procFault} = 6'h20;
      {procTerm, equipFault, equipMayTerm, progExc, progTerm} = 5'h00;
      {fpCheck, fpAddSub, fpZeroFrac, iacwCheck, iacwAFlag} = 5'h00;
      {regAddr, regWrData, ioChan, slowness, iacwCount} = 20'h00000;
      ioKind = MCP_IOK_ADDRPROT;
      procKind = MCP_PRK_ADDRPROT;
      progCause = MCP_PX_OPER;
      fpExp = 10'sd0;
      void'($urandom(3333));
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rd(2'h0, 8'h00);
      wr(2'h0, 8'h3F);
      rd(2'h0, 8'h3F);
      wr(2'h1, 8'hFF);
      rd(2'h1, 8'h00);
      rd(2'h3, 8'h00);
      $display("test registers done");
      // i/o check held while machine-check mask is 0
      wr(2'h0, 8'h01);
      @(posedge clk);
      ioFault <= 1'b1;
      ioChan <= 3'h2;
      ioKind <= MCP_IOK_ADDRPROT;
      finish_ev(10'h000, 1'b0);
      check({9'h000, entrySeqReq}, 10'h000);
      rd(2'h2, 8'h02);
      wr(2'h0, 8'h3F);
      finish_ev({2'b01, 8'h25}, 1'b1);
      for (int k = 0; k < 6; k++) begin
         arm();
         c = 3'($urandom);
         ioFault <= 1'b1;
         ioKind <= mcp_io_kind_t'(k);
         ioChan <= c;
         if (k < 4) begin
            finish_ev({2'b01, 1'b0, c, ioNib[k]}, 1'b1);
         end else begin
            finish_ev({2'b01, 4'h0, ioNib[k]}, 1'b1);
         end
      end
      $display("test io checks done");
      for (int k = 0; k < 7; k++) begin
         arm();
         procFault <= 1'b1;
         procKind <= mcp_proc_kind_t'(k);
         finish_ev({2'b10, 3'h7, t, prNib[k]}, 1'b1);
      end
      $display("test processor checks done");
      for (int k = 0; k < 12; k++) begin
         arm();
         progExc <= 1'b1;
         progCause <= mcp_prog_cause_t'(pgc[k]);
         finish_ev({2'b10, 3'h0, t, pgc[k]}, 1'b1);
      end
      // floating-point results, 127 is the quiet boundary
      for (int k = 0; k < 4; k++) begin
         arm();
         fpCheck <= 1'b1;
         fpExp <= (k == 0) ? 10'sd128 : (k == 1) ? -10'sd1 : 10'sd127;
         fpAddSub <= (k == 2);
         fpZeroFrac <= (k == 2);
         finish_ev({2'b10, 3'h0, t, 4'hC + 4'(k)}, k < 3);
      end
      // indirect words: flag, chain of 9, chain of 8 is fine
      for (int k = 0; k < 3; k++) begin
         arm();
         iacwCheck <= 1'b1;
         iacwAFlag <= (k == 0);
         iacwCount <= (k == 2) ? 4'h8 : 4'h9;
         finish_ev({2'b10, 3'h1, t, 4'h5 + 4'(k)}, k < 2);
      end
      $display("test program exceptions done");
      // program mask bit B off: overflow ignored
      wr(2'h0, 8'h3B);
      arm();
      progExc <= 1'b1;
      progCause <= MCP_PX_FXOVF;
      finish_ev(10'h000, 1'b0);
      check({8'h00, abortInstr, entrySeqReq}, 10'h000);
      // exception mask off: becomes a processor check
      wr(2'h0, 8'h3E);
      arm();
      progExc <= 1'b1;
      progCause <= MCP_PX_OPER;
      finish_ev({2'b10, 3'h7, t, 4'hC}, 1'b1);
      // equipment line, ordinary instruction completes first
      arm();
      equipFault <= 1'b1;
      finish_ev({2'b01, 8'hE0}, 1'b1);
      equipFault <= 1'b0;
      // terminable instruction: equipment check cuts it short
      @(posedge clk);
      equipMayTerm <= 1'b1;
      equipFault <= 1'b1;
      arm();
      finish_ev({2'b10, 8'hF0}, 1'b1);
      {equipFault, equipMayTerm} <= 2'b00;
      $display("test masks and equipment done");
      // processor check with machine-check mask off is fatal
      wr(2'h0, 8'h00);
      arm();
      procFault <= 1'b1;
      @(posedge clk);
      procFault <= 1'b0;
      repeat (4) @(posedge clk);
      rd(2'h2, 8'h38);
      check({4'h0, nonrecov, cycleMode, chanSysReset, checkOut,
             checkLamp, procStop}, 10'h03F);
      check({9'h000, entrySeqReq}, 10'h000);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(2'h0, 8'h00);
      @(posedge clk);
      check({4'h0, nonrecov, procStop, entrySeqReq, 3'h0}, 10'h000);
      check(10'(evQ.size()), 10'h000);
      $display("test fatal error done");
      report_and_stop;
   end
endmodule // tb_top
